/* core/sensor_ctrl.sv */
// Control and configuration core of the optical sensor.
// Assumes a byte register port decoded from the serial interface,
// with one-cycle write and read strobes.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Reset bit write starts forced reset sequence
// - Reset bit self-clears when sequence ends
// - Forced reset completion sets power-up flag
// - Main config applies at next period, except the enable bit, which applies at once
// - Enable low forces ambient flag zero
// - Enable high lets event set flag
// - Set flag drives interrupt pin low
// - Status read clears flags, releases pin
// - Source select picks compared channel
// - Mode selects set of active channels
// - Temperature channel needs its enable bit
// - Ambient config write restarts conversion immediately
// - Gain code sets colour channel LSB
// - Blue LSB twice other channels, except both are 2047 at gain code 3 outside 400 ms
// - 400 ms integration quarters LSB
// - Time code selects period and resolution
// - Temperature follows clear channel and timing
module sensor_ctrl #(
   parameter int UNIT_CYC = sensor_ctrl_pkg::CONV_UNIT_CYC // Cycles per 1.5625 ms
) (
   input wire logic core_clk, // Core clock, 20 MHz
   input wire logic reset_n, // Async reset, active low
   input wire logic [7:0] reg_addr, // Register address
   input wire logic [7:0] reg_wdata, // Write data
   input wire logic reg_wr, // Write strobe
   input wire logic reg_rd, // Read strobe
   input wire logic amb_event, // Ambient threshold event pulse
   output logic [7:0] reg_rdata, // Read data
   output logic int_n, // Interrupt pin, active low
   output logic hw_reset_pulse, // Internal hardware reset pulse
   output logic [5:0] chan_active, // Active channel enables
   output logic [1:0] irq_source_select, // Compared channel
   output logic [1:0] channel_gain_sel, // Active gain
   output logic [2:0] integration_time_sel, // Active time code
   output logic [3:0] result_bits, // Result resolution
   output logic [10:0] lsb_quarter_nw, // Colour LSB in 0.25 nW/cm2
   output logic [10:0] blue_lsb_quarter_nw, // Blue LSB in 0.25 nW/cm2
   output logic ir_comp_enable, // IR compensation enable
   output logic trim_enable, // Trim gain select
   output logic conv_start // New conversion start pulse
);
   logic [7:0] main_cfg_reg; // Main configuration as written
   logic [7:0] amb_cfg_reg; // Ambient configuration
   logic [7:0] main_live_reg; // Main configuration in force
   logic power_up_flag; // Power-up flag
   logic ambient_irq_flag; // Ambient flag
   logic shdn_reg; // Shutdown bit storage
   logic reset_bit_reg; // Reset control bit
   logic [3:0] rst_cnt_reg; // Forced reset pulse counter
   logic period_end; // Conversion period end
   logic restart; // Conversion restart
   logic [8:0] units; // Period length in units
   logic wr_status, wr_main, wr_amb, rd_status; // Decoded accesses
   logic ambient_irq_enable; // Enable bit from the main configuration as written

   // Decodes an integration time code to base units
   function automatic logic [8:0] time_units(input logic [2:0] code);
      case (code)
         3'h0: time_units = 9'h040; // 100 ms
         3'h1: time_units = 9'h010; // 25 ms
         3'h2: time_units = 9'h004; // 6.25 ms
         3'h3: time_units = 9'h001; // 1.5625 ms
         3'h4: time_units = 9'h100; // 400 ms
         default: time_units = 9'h040; // Reserved codes run as 100 ms
      endcase
   endfunction : time_units

   assign wr_status = reg_wr && reg_addr == sensor_ctrl_pkg::STATUS_ADDR;
   assign wr_main = reg_wr && reg_addr == sensor_ctrl_pkg::MAIN_CFG_ADDR;
   assign wr_amb = reg_wr && reg_addr == sensor_ctrl_pkg::AMB_CFG_ADDR;
   assign rd_status = reg_rd && reg_addr == sensor_ctrl_pkg::STATUS_ADDR;
   assign ambient_irq_enable = main_cfg_reg[sensor_ctrl_pkg::MC_IRQ_EN_BIT];
   assign restart = wr_amb || reset_bit_reg;
   assign units = time_units(amb_cfg_reg[sensor_ctrl_pkg::AC_TIME_LSB +: 3]);

   // Conversion period timer
   conv_timer #(.UNIT_CYC(UNIT_CYC)) conv_timer_i (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .restart(restart),
      .units(units),
      .period_end(period_end)
   );

   // Forced reset sequence: bit set, counted pulse, self-clear
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         reset_bit_reg <= 1'b0;
         rst_cnt_reg <= 4'h0;
         hw_reset_pulse <= 1'b0;
      end else if (reset_bit_reg) begin
         hw_reset_pulse <= 1'b1;
         if (rst_cnt_reg == 4'(sensor_ctrl_pkg::RESET_PULSE_CYC - 1)) begin
            reset_bit_reg <= 1'b0;
            rst_cnt_reg <= 4'h0;
         end else begin
            rst_cnt_reg <= rst_cnt_reg + 4'h1;
         end
      end else begin
         hw_reset_pulse <= 1'b0;
         if (wr_status && reg_wdata[sensor_ctrl_pkg::ST_RESET_BIT]) begin
            reset_bit_reg <= 1'b1;
         end
      end
   end

   // Configuration registers, returned to power-on values by forced reset
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         main_cfg_reg <= sensor_ctrl_pkg::MAIN_CFG_RESET;
         amb_cfg_reg <= sensor_ctrl_pkg::AMB_CFG_RESET;
         shdn_reg <= 1'b0;
      end else if (reset_bit_reg) begin
         main_cfg_reg <= sensor_ctrl_pkg::MAIN_CFG_RESET;
         amb_cfg_reg <= sensor_ctrl_pkg::AMB_CFG_RESET;
         shdn_reg <= 1'b0;
      end else begin
         if (wr_main) begin
            main_cfg_reg <= reg_wdata & 8'h3D;
         end
         if (wr_amb) begin
            amb_cfg_reg <= reg_wdata;
         end
         if (wr_status) begin
            shdn_reg <= reg_wdata[sensor_ctrl_pkg::ST_SHDN_BIT];
         end
      end
   end

   // Main settings take hold at a period boundary or on a restart
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         main_live_reg <= sensor_ctrl_pkg::MAIN_CFG_RESET;
      end else if (period_end || restart) begin
         main_live_reg <= main_cfg_reg;
      end
   end

   // Interrupt flags: event set wins over read clear
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         power_up_flag <= 1'b1;
         ambient_irq_flag <= 1'b0;
      end else begin
         if (reset_bit_reg && rst_cnt_reg == 4'(sensor_ctrl_pkg::RESET_PULSE_CYC - 1)) begin
            power_up_flag <= 1'b1;
         end else if (rd_status) begin
            power_up_flag <= 1'b0;
         end
         if (!ambient_irq_enable || reset_bit_reg || shdn_reg) begin
            ambient_irq_flag <= 1'b0;
         end else if (amb_event) begin
            ambient_irq_flag <= 1'b1;
         end else if (rd_status) begin
            ambient_irq_flag <= 1'b0;
         end
      end
   end

   // Interrupt pin, one cycle behind the flags
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         int_n <= 1'b1;
      end else begin
         int_n <= !(power_up_flag || ambient_irq_flag);
      end
   end

   // Read data mux
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            sensor_ctrl_pkg::STATUS_ADDR: reg_rdata <= {3'b000, reset_bit_reg, shdn_reg,
               power_up_flag, 1'b0, ambient_irq_flag};
            sensor_ctrl_pkg::MAIN_CFG_ADDR: reg_rdata <= main_cfg_reg;
            sensor_ctrl_pkg::AMB_CFG_ADDR: reg_rdata <= amb_cfg_reg;
            default: reg_rdata <= 8'h00;
         endcase
      end
   end

   // Channel activation and conversion settings
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         chan_active <= 6'h00;
         irq_source_select <= 2'b00;
         channel_gain_sel <= 2'b00;
         integration_time_sel <= 3'b000;
         result_bits <= 4'hE;
         lsb_quarter_nw <= 11'h008;
         blue_lsb_quarter_nw <= 11'h010;
         ir_comp_enable <= 1'b0;
         trim_enable <= 1'b0;
         conv_start <= 1'b0;
      end else begin
         conv_start <= restart || period_end;
         irq_source_select <= main_live_reg[sensor_ctrl_pkg::MC_SRC_LSB +: 2];
         channel_gain_sel <= amb_cfg_reg[sensor_ctrl_pkg::AC_GAIN_LSB +: 2];
         integration_time_sel <= amb_cfg_reg[sensor_ctrl_pkg::AC_TIME_LSB +: 3];
         ir_comp_enable <= amb_cfg_reg[sensor_ctrl_pkg::AC_COMP_EN_BIT];
         trim_enable <= amb_cfg_reg[sensor_ctrl_pkg::AC_TRIM_BIT];
         case (main_live_reg[sensor_ctrl_pkg::MC_MODE_LSB +: 2])
            2'b00: chan_active[4:0] <= 5'b00001;
            2'b01: chan_active[4:0] <= 5'b10001;
            2'b10: chan_active[4:0] <= 5'b11111;
            default: chan_active[4:0] <= 5'b00000;
         endcase
         chan_active[sensor_ctrl_pkg::CH_TEMP] <= amb_cfg_reg[sensor_ctrl_pkg::AC_TEMP_EN_BIT]
            && main_live_reg[5:4] != 2'b11;
         case (amb_cfg_reg[sensor_ctrl_pkg::AC_TIME_LSB +: 3])
            3'h1: result_bits <= 4'hC;
            3'h2: result_bits <= 4'hA;
            3'h3: result_bits <= 4'h8;
            default: result_bits <= 4'hE;
         endcase
         // Quarter-nW units: 100 ms gives 8,32,128,2047; 400 ms gives 2,8,32,512
         case (amb_cfg_reg[sensor_ctrl_pkg::AC_GAIN_LSB +: 2])
            2'b00: lsb_quarter_nw <= 11'h008;
            2'b01: lsb_quarter_nw <= 11'h020;
            2'b10: lsb_quarter_nw <= 11'h080;
            default: lsb_quarter_nw <= 11'h7FF;
         endcase
         if (amb_cfg_reg[sensor_ctrl_pkg::AC_TIME_LSB +: 3] == 3'h4) begin
            case (amb_cfg_reg[1:0])
               2'b00: lsb_quarter_nw <= 11'h002;
               2'b01: lsb_quarter_nw <= 11'h008;
               2'b10: lsb_quarter_nw <= 11'h020;
               default: lsb_quarter_nw <= 11'h200;
            endcase
         end
         blue_lsb_quarter_nw <= 11'h000;
         case ({amb_cfg_reg[sensor_ctrl_pkg::AC_TIME_LSB +: 3] == 3'h4, amb_cfg_reg[1:0]})
            3'b000: blue_lsb_quarter_nw <= 11'h010;
            3'b001: blue_lsb_quarter_nw <= 11'h040;
            3'b010: blue_lsb_quarter_nw <= 11'h100;
            3'b011: blue_lsb_quarter_nw <= 11'h7FF;
            3'b100: blue_lsb_quarter_nw <= 11'h004;
            3'b101: blue_lsb_quarter_nw <= 11'h010;
            3'b110: blue_lsb_quarter_nw <= 11'h040;
            default: blue_lsb_quarter_nw <= 11'h400;
         endcase
      end
   end

   // Steps of a forced reset: the bit rises, stands four cycles, then drops
   sequence reset_bit_rise_s;
      $rose(reset_bit_reg);
   endsequence
   sequence reset_bit_hold_s;
      reset_bit_reg [*4] ##1 !reset_bit_reg;
   endsequence
   sequence reset_pulse_hold_s;
      hw_reset_pulse [*4] ##1 !hw_reset_pulse;
   endsequence

   // Assertions
   AST_RESET_STEPS: assert property (@(posedge core_clk) disable iff (!reset_n)
      reset_bit_rise_s |-> reset_bit_hold_s ##0 power_up_flag)
      else $error("forced reset steps out of order");
   AST_RESET_PULSE_LEN: assert property (@(posedge core_clk) disable iff (!reset_n)
      reset_bit_rise_s |=> reset_pulse_hold_s)
      else $error("forced reset pulse length wrong");
   AST_MODE_CLEAR: assert property (@(posedge core_clk) disable iff (!reset_n)
      main_live_reg[sensor_ctrl_pkg::MC_MODE_LSB +: 2] == 2'b00 |=> chan_active[4:0] == 5'b00001)
      else $error("clear only mode enables wrong channels");
   AST_TEMP_GATE: assert property (@(posedge core_clk) disable iff (!reset_n)
      !amb_cfg_reg[sensor_ctrl_pkg::AC_TEMP_EN_BIT] |=> !chan_active[sensor_ctrl_pkg::CH_TEMP])
      else $error("temperature channel on while disabled");
   AST_RESET_SELF_CLEAR: assert property (@(posedge core_clk) disable iff (!reset_n)
      $rose(reset_bit_reg) |-> ##[1:8] !reset_bit_reg)
      else $error("reset bit did not clear");
   AST_RESET_PULSE: assert property (@(posedge core_clk) disable iff (!reset_n)
      $rose(reset_bit_reg) |=> hw_reset_pulse)
      else $error("no hardware reset pulse");
   AST_PWR_FLAG: assert property (@(posedge core_clk) disable iff (!reset_n)
      $fell(reset_bit_reg) |-> power_up_flag)
      else $error("power flag not set after reset");
   AST_AMB_MASK: assert property (@(posedge core_clk) disable iff (!reset_n)
      !ambient_irq_enable |=> !ambient_irq_flag)
      else $error("ambient flag set while disabled");
   AST_AMB_SET: assert property (@(posedge core_clk) disable iff (!reset_n)
      ambient_irq_enable && amb_event && !reset_bit_reg && !shdn_reg
      |=> ambient_irq_flag)
      else $error("ambient event lost");
   AST_INT_PIN: assert property (@(posedge core_clk) disable iff (!reset_n)
      ambient_irq_flag |=> !int_n)
      else $error("pin not low with flag set");
   AST_READ_CLEAR: assert property (@(posedge core_clk) disable iff (!reset_n)
      rd_status && !amb_event && !reset_bit_reg |=> !ambient_irq_flag)
      else $error("status read did not clear flag");
   AST_MAIN_HOLD: assert property (@(posedge core_clk) disable iff (!reset_n)
      !period_end && !restart |=> $stable(main_live_reg))
      else $error("main settings changed mid period");
   AST_AMB_RESTART: assert property (@(posedge core_clk) disable iff (!reset_n)
      wr_amb |=> conv_start)
      else $error("ambient write did not restart");
endmodule : sensor_ctrl
`default_nettype wire

/* core/sensor_ctrl_pkg.sv */
// Package for the optical sensor control and configuration block.
// Assumes a single 20 MHz core clock and a byte-wide register port.
package sensor_ctrl_pkg;
   // Register offsets
   localparam logic [7:0] STATUS_ADDR = 8'h00; // Interrupt status
   localparam logic [7:0] MAIN_CFG_ADDR = 8'h01; // Main configuration
   localparam logic [7:0] AMB_CFG_ADDR = 8'h02; // Ambient configuration
   // Reset values
   localparam logic [7:0] MAIN_CFG_RESET = 8'h20;
   localparam logic [7:0] AMB_CFG_RESET = 8'h00;
   // Status bit positions
   localparam int ST_AMB_FLAG_BIT = 0;
   localparam int ST_PWR_FLAG_BIT = 2;
   localparam int ST_SHDN_BIT = 3;
   localparam int ST_RESET_BIT = 4;
   // Main configuration fields
   localparam int MC_IRQ_EN_BIT = 0;
   localparam int MC_SRC_LSB = 2;
   localparam int MC_MODE_LSB = 4;
   // Ambient configuration fields
   localparam int AC_GAIN_LSB = 0;
   localparam int AC_TIME_LSB = 2;
   localparam int AC_TEMP_EN_BIT = 5;
   localparam int AC_COMP_EN_BIT = 6;
   localparam int AC_TRIM_BIT = 7;
   // Forced reset pulse length
   localparam int RESET_PULSE_NS = 200;
   localparam int CLK_PERIOD_NS = 50;
   localparam int RESET_PULSE_CYC = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Conversion base period (1.5625 ms unit) in cycles of the 20 MHz core clock
   localparam int CONV_UNIT_CYC = 31250;
   // Channel enable bit positions
   localparam int CH_CLEAR = 0;
   localparam int CH_RED = 1;
   localparam int CH_GREEN = 2;
   localparam int CH_BLUE = 3;
   localparam int CH_IR = 4;
   localparam int CH_TEMP = 5;
endpackage : sensor_ctrl_pkg

/* core/conv_timer.sv */
// Conversion period timer: counts integration time in base units.
// Takes restart from the control logic: one cycle per ambient write, four cycles during a forced reset.
`timescale 1ns/100ps
`default_nettype none
module conv_timer #(
   parameter int UNIT_CYC = sensor_ctrl_pkg::CONV_UNIT_CYC
) (
   input wire logic core_clk, // Core clock
   input wire logic reset_n, // Async reset, active low
   input wire logic restart, // Abort and start a new period
   input wire logic [8:0] units, // Period length in base units
   output logic period_end // One-cycle pulse at period end
);
   logic [15:0] unit_cnt_reg; // Cycles within unit
   logic [8:0] unit_idx_reg; // Units elapsed

   // Base unit divider and unit counter
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         unit_cnt_reg <= 16'h0000;
         unit_idx_reg <= 9'h000;
         period_end <= 1'b0;
      end else if (restart) begin
         unit_cnt_reg <= 16'h0000;
         unit_idx_reg <= 9'h000;
         period_end <= 1'b0;
      end else if (unit_cnt_reg == 16'(UNIT_CYC - 1)) begin
         unit_cnt_reg <= 16'h0000;
         if (unit_idx_reg + 9'h001 >= units) begin
            unit_idx_reg <= 9'h000;
            period_end <= 1'b1;
         end else begin
            unit_idx_reg <= unit_idx_reg + 9'h001;
            period_end <= 1'b0;
         end
      end else begin
         unit_cnt_reg <= unit_cnt_reg + 16'h0001;
         period_end <= 1'b0;
      end
   end
endmodule : conv_timer
`default_nettype wire

/* test/host_model.sv */
// Host side of the byte register port, driving one-cycle strobes.
// Assumes the caller samples read data itself, one edge after the strobe.
`timescale 1ns/100ps
`default_nettype none
module host_model (
   input wire logic core_clk, // Core clock
   output logic [7:0] reg_addr, // Register address
   output logic [7:0] reg_wdata, // Write data
   output logic reg_wr, // Write strobe
   output logic reg_rd // Read strobe
);
   // Idle port before the first request
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   // One write; released lines show the inverse of the last value
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask : wr
   // One read; a status read is how the host clears its flags
   task automatic rd(input logic [7:0] a);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
   endtask : rd
endmodule : host_model
`default_nettype wire

/* test/tb_sensor_ctrl.sv */
// Self-checking bench for the sensor control core.
// Assumes the host model in host_model.sv and a shortened conversion unit.
`timescale 1ns/100ps
`default_nettype none
module tb_sensor_ctrl;
   logic core_clk = 1'b0; // Core clock
   logic reset_n = 1'b0; // Reset, active low
   logic amb_event = 1'b0; // Ambient event pulse
   wire logic [7:0] reg_addr, reg_wdata;
   wire logic reg_wr, reg_rd;
   logic [7:0] reg_rdata, amb, r;
   logic int_n, hw_reset_pulse, ir_comp_enable, trim_enable, conv_start;
   logic [5:0] chan_active, ec;
   logic [1:0] irq_source_select, channel_gain_sel;
   logic [2:0] integration_time_sel;
   logic [3:0] result_bits;
   logic [10:0] lsb_quarter_nw, blue_lsb_quarter_nw;
   logic [11:0] base;
   int n_mismatch = 0, cmp_count = 0, cyc = 0, i, k, j;
   logic [7:0] exp_q[$]; // Expected read data, oldest first
   host_model host_model_i (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd));
   sensor_ctrl #(.UNIT_CYC(4)) sensor_ctrl_i (.core_clk(core_clk), .reset_n(reset_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .amb_event(amb_event), .reg_rdata(reg_rdata), .int_n(int_n),
      .hw_reset_pulse(hw_reset_pulse), .chan_active(chan_active),
      .irq_source_select(irq_source_select), .channel_gain_sel(channel_gain_sel),
      .integration_time_sel(integration_time_sel), .result_bits(result_bits),
      .lsb_quarter_nw(lsb_quarter_nw), .blue_lsb_quarter_nw(blue_lsb_quarter_nw),
      .ir_comp_enable(ir_comp_enable), .trim_enable(trim_enable), .conv_start(conv_start));
   // Clock
   initial forever #25 core_clk = ~core_clk;
   // Compare and count
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic print_verdict;
      $display("Counts: %0d compares, %0d mismatches", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : print_verdict
   // Note the expected byte, then read
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      host_model_i.rd(a);
   endtask : rd
   // Main write, then ambient write so main settings take effect now
   task automatic set_main(input logic [7:0] m, input logic [7:0] a);
      host_model_i.wr(8'h01, m);
      host_model_i.wr(8'h02, a);
      repeat (3) @(posedge core_clk);
   endtask : set_main
   task automatic pulse_event;
      @(posedge core_clk) amb_event <= 1'b1;
      @(posedge core_clk) amb_event <= 1'b0;
      repeat (3) @(posedge core_clk);
   endtask : pulse_event
   // Read data monitor: one result the cycle after each strobe
   always @(posedge core_clk) begin
      if (reg_rd === 1'b1) begin
         #1;
         check(reg_rdata, exp_q.pop_front());
      end
   end
   // Hang guard
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         print_verdict();
      end
   end
   // Main sequence
   initial begin
      void'($urandom(32'h9cea));
      repeat (16) @(posedge core_clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      check(int_n, 1'b0);
      check(chan_active, 6'h1F);
      rd(8'h01, 8'h20);
      rd(8'h02, 8'h00);
      rd(8'h00, 8'h04);
      repeat (3) @(posedge core_clk);
      check(int_n, 1'b1);
      $display("test reset values done");
      // Every mode and source, temperature on and off
      for (i = 0; i < 8; i++) begin
         set_main({2'b00, i[1:0], i[1:0], 2'b00}, {2'b00, i[2], 5'b00000});
         ec = (i[1:0] == 2'd0) ? 6'h01 : (i[1:0] == 2'd1) ? 6'h11 : (i[1:0] == 2'd2) ? 6'h1F : 6'h00;
         if (i[1:0] != 2'd3 && i[2]) ec = ec | 6'h20;
         check(chan_active, ec);
         check(irq_source_select, i[1:0]);
      end
      host_model_i.wr(8'h01, 8'hFF);
      rd(8'h01, 8'h3D);
      // Main write waits for the period end
      set_main(8'h00, 8'h00);
      host_model_i.wr(8'h01, 8'h04);
      repeat (3) @(posedge core_clk);
      check(irq_source_select, 2'h0);
      repeat (262) @(posedge core_clk);
      check(irq_source_select, 2'h1);
      $display("test modes done");
      // Gain and time codes with random trim and compensation bits
      for (i = 0; i < 5; i++) begin
         for (k = 0; k < 4; k++) begin
            r = 8'($urandom);
            amb = {r[1:0], 1'b0, i[2:0], k[1:0]};
            host_model_i.wr(8'h02, amb);
            #1;
            j = 0;
            while (conv_start !== 1'b1 && j < 6) begin
               @(posedge core_clk);
               #1;
               j++;
            end
            check(16'(j), 16'h0000);
            repeat (2) @(posedge core_clk);
            check(channel_gain_sel, k[1:0]);
            check(integration_time_sel, i[2:0]);
            check(result_bits, (i == 4) ? 4'd14 : 4'(14 - 2 * i));
            check({trim_enable, ir_comp_enable}, r[1:0]);
            base = (k == 0) ? 12'd8 : (k == 1) ? 12'd32 : (k == 2) ? 12'd128 : 12'd2048;
            if (i == 4) base = base >> 2;
            if (i == 0 || i == 4) begin
               check(lsb_quarter_nw, (base > 2047) ? 11'h7FF : base[10:0]);
               check(blue_lsb_quarter_nw, (2 * base > 2047) ? 11'h7FF : 11'(2 * base));
            end
         end
      end
      $display("test gain and time done");
      // Interrupt enable, flag, pin and clearing read
      set_main(8'h21, 8'h00);
      pulse_event();
      check(int_n, 1'b0);
      rd(8'h00, 8'h01);
      repeat (3) @(posedge core_clk);
      check(int_n, 1'b1);
      pulse_event();
      set_main(8'h20, 8'h00);
      rd(8'h00, 8'h00);
      pulse_event();
      check(int_n, 1'b1);
      $display("test interrupt done");
      // Forced reset sequence
      set_main(8'h15, 8'h1F);
      host_model_i.wr(8'h00, 8'h10);
      k = 0;
      repeat (8) begin
         @(posedge core_clk);
         #1;
         k += int'(hw_reset_pulse);
      end
      check(16'(k), 16'h0004);
      check(int_n, 1'b0);
      rd(8'h00, 8'h04);
      rd(8'h01, 8'h20);
      rd(8'h02, 8'h00);
      $display("test forced reset done");
      repeat (5) @(posedge core_clk);
      print_verdict();
   end
endmodule : tb_sensor_ctrl
`default_nettype wire
